// ### nvm_page_program_sequencer_tb.sv
/*
  Self-checking bench of the page program sequencer.
  Assumes the cpu model drives the bus and the checker is bound.
*/
`timescale 1ns/1ns
`include "nvmps_defines.vh"

module nvm_page_program_sequencer_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sleep_wake = 1'b0;
  wire wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, flash_busy_flag, eeprom_busy_flag;
  wire [3:0] wb_sel_i;
  wire [19:0] wb_adr_i;
  wire [31:0] wb_dat_i, wb_dat_o;
  int failures = 0;
  int tests_run = 0;
  int cyc_cnt = 0;
  int n, o;
  logic [31:0] q, d1, d2, v;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  localparam logic [19:0] CM = 20'h00000;
  localparam logic [19:0] ST = 20'h0000c;

  always #4 clk = ~clk;

  nvmps_sequencer u_dut (.clk(clk), .rst_n(rst_n), .sleep_wake(sleep_wake), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .flash_busy_flag(flash_busy_flag), .eeprom_busy_flag(eeprom_busy_flag));
  nvmps_cpu_model u_cpu (.clk(clk), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i));

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [19:0] fa(input int p, input int b);
    return 20'h08000 + 20'(p * 512 + b);
  endfunction
  function automatic logic [19:0] ea(input int b);
    return 20'h01000 + 20'(b);
  endfunction
  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    u_cpu.xfer(1'b1, a, d, q, n);
  endtask
  task automatic rd(input logic [19:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    u_cpu.xfer(1'b0, a, 32'h0, q, n);
  endtask
  task automatic chk_dat(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value at %0t: read %h, expected %h", $time, g, e);
    end
  endtask
  task automatic chk_ok(input bit ok);
    tests_run++;
    if (!ok)
    begin
      failures++;
      $display("wrong value at %0t: answer after %0d cycles", $time, n);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // buffer byte, then clear by command or wake, then write
  task automatic clr_chk(input bit wake, input int k);
    u_cpu.cmd(`NVMPS_CMD_NONE, n);
    wr(fa(2, k), 32'h0);
    if (wake)
    begin
      sleep_wake <= 1'b1;
      @(posedge clk);
      sleep_wake <= 1'b0;
    end
    else
    begin
      u_cpu.cmd(`NVMPS_CMD_FL_BCLR, n);
      chk_ok(n >= 8);
    end
    u_cpu.cmd(`NVMPS_CMD_FL_PW, n);
    wr(fa(2, k), 32'hff);
    rd(fa(2, k), 32'hff, '1);
  endtask

  // answered reads are matched with the oldest note
  always @(posedge clk)
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
      chk_dat(wb_dat_o & msk_q.pop_front(), exp_q.pop_front());

  // cut a hang short
  always @(posedge clk)
  begin
    cyc_cnt++;
    if (cyc_cnt == 90000)
    begin
      failures++;
      wrap_up;
    end
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    void'($urandom(32'h0274));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(ST, 32'h0, 32'h3);
    wr(20'h20000, 32'h5a);
    rd(20'h20000, 32'h0, '1);
    wr(CM, 32'(`NVMPS_CMD_FL_PW));
    rd(CM, 32'h0, 32'h7f);
    // split erase, then and-merged buffer written to page 2
    u_cpu.cmd(`NVMPS_CMD_FL_PER, n);
    rd(CM, 32'(`NVMPS_CMD_FL_PER), 32'h7f);
    // the unlock lapses after four further accesses
    wr({12'h000, `NVMPS_REG_UNLOCK}, {24'h0, `NVMPS_UNLOCK_KEY});
    repeat (4) rd(ST, 32'h0, 32'h3);
    wr(CM, 32'(`NVMPS_CMD_NONE));
    rd(CM, 32'(`NVMPS_CMD_FL_PER), 32'h7f);
    wr(fa(2, 9), $urandom & 32'hff);
    rd(fa(2, 511), 32'hff, '1);
    o = $urandom_range(127);
    d1 = $urandom & 32'hff;
    d2 = $urandom & 32'hff;
    u_cpu.cmd(`NVMPS_CMD_NONE, n);
    wr(fa(2, o), d1);
    wr(fa(2, o), d2);
    u_cpu.cmd(`NVMPS_CMD_FL_PW, n);
    wr(fa(2, o + 256), 32'hff);
    rd(fa(2, o), d1 & d2, '1);
    rd(fa(2, o + 256), 32'hff, '1);
    u_cpu.cmd(`NVMPS_CMD_FL_PERW, n);
    wr(fa(2, o + 1), d1);
    rd(fa(2, o), 32'hff, '1);
    rd(fa(2, o + 1), d1, '1);
    clr_chk(1'b0, 500);
    clr_chk(1'b1, 501);
    // multi-page erase of aligned groups, one page beyond kept
    for (int k = 1; k <= 5; k++)
    begin
      u_cpu.cmd(`NVMPS_CMD_FL_PERW, n);
      wr(fa((1 << k) - 1, 0), 32'h0);
      wr(fa(1 << k, 0), 32'h0);
      u_cpu.cmd({`NVMPS_CMD_MPER_BASE, 3'(k)}, n);
      wr(fa(0, 3), 32'hff);
      rd(fa((1 << k) - 1, 0), 32'hff, '1);
      rd(fa(1 << k, 0), 32'h0, '1);
    end
    // window 1 store; the window moves back while it runs
    v = $urandom & 32'h7f;
    u_cpu.cmd(`NVMPS_CMD_FL_PERW, n);
    wr(20'h00008, 32'h1);
    wr(fa(0, 1), v);
    wr(20'h00008, 32'h0);
    wr(20'h00010, 32'h8001);
    rd(20'h00014, v, '1);
    wr(20'h00010, 32'h8000);
    rd(20'h00014, 32'hff, '1);
    rd(fa(0, 1), 32'hff, '1);
    wr(20'h01405, d2);
    rd(20'h01405, d2, '1);
    rd(20'h0143f, 32'hff, '1);
    // eeprom: full erase, byte write, byte erase, erase-write, clear
    u_cpu.cmd(`NVMPS_CMD_EE_FULL, n);
    chk_ok(n > 512);
    o = $urandom_range(255) * 2;
    rd(ea(o), 32'hff, '1);
    u_cpu.cmd(`NVMPS_CMD_EE_PW, n);
    wr(ea(o), d1);
    rd(ST, 32'h1, 32'h3);
    chk_ok(n == 2);
    rd(ea(o), d1, '1);
    rd(ea(o + 1), 32'hff, '1);
    u_cpu.cmd(`NVMPS_CMD_EE_PER, n);
    wr(ea(o), 32'h0);
    rd(ea(o), 32'hff, '1);
    u_cpu.cmd(`NVMPS_CMD_EE_PERW, n);
    wr(ea(o + 1), d2);
    rd(ea(o + 1), d2, '1);
    u_cpu.cmd(`NVMPS_CMD_EE_BCLR, n);
    chk_ok(n >= 8);
    wrap_up;
  end
endmodule // nvm_page_program_sequencer_tb

// ### nvmps_cpu_model.sv
/*
  Cpu core model: classic Wishbone master for loads, stores, commands.
  Assumes a free-running clk and a slave that answers with ack.
*/
`timescale 1ns/1ns
`include "nvmps_defines.vh"

module nvmps_cpu_model (
  input wire clk,
  input wire wb_ack_o,
  input wire [31:0] wb_dat_o,
  output reg wb_cyc_i,
  output reg wb_stb_i,
  output reg wb_we_i,
  output reg [3:0] wb_sel_i,
  output reg [19:0] wb_adr_i,
  output reg [31:0] wb_dat_i
);
  // idle bus at time zero
  initial
  begin
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_sel_i = 4'hf;
    wb_adr_i = 20'h00000;
    wb_dat_i = 32'h00000000;
  end

  // ************************************************************
  // one bus cycle, held until ack is sampled
  // ************************************************************
  task automatic xfer(input logic w, input logic [19:0] a, input logic [31:0] d,
    output logic [31:0] q, output int n);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_adr_i <= ~a; // released lines lose their value
    wb_dat_i <= ~d;
  endtask

  // unlock, then write the command at once
  task automatic cmd(input logic [6:0] c, output int n);
    logic [31:0] q;
    xfer(1'b1, {12'h000, `NVMPS_REG_UNLOCK}, {24'h0, `NVMPS_UNLOCK_KEY}, q, n);
    xfer(1'b1, {12'h000, `NVMPS_REG_CMD}, {25'h0, c}, q, n);
  endtask
endmodule // nvmps_cpu_model

// ### nvmps_defines.vh
/*
  Constants of the page program sequencer: bus map, register offsets,
  command codes, unlock key and stall counts.
  Assumes it is included by bare name from the sequencer design files.
*/
`ifndef NVMPS_DEFINES_VH
`define NVMPS_DEFINES_VH

// ************************************************************
// bus regions (byte addresses, 20-bit bus address)
// ************************************************************
`define NVMPS_RGN_REG 12'h000
`define NVMPS_RGN_EE 11'h008
`define NVMPS_RGN_UR 14'h0050
`define NVMPS_RGN_FL 5'h01

// ************************************************************
// register offsets inside the register region
// ************************************************************
`define NVMPS_REG_CMD 8'h00
`define NVMPS_REG_UNLOCK 8'h04
`define NVMPS_REG_WINDOW 8'h08
`define NVMPS_REG_STATUS 8'h0c
`define NVMPS_REG_PTR 8'h10
`define NVMPS_REG_PMDATA 8'h14

// ************************************************************
// field positions and reset values
// ************************************************************
`define NVMPS_STAT_EE_BIT 0
`define NVMPS_STAT_FL_BIT 1
`define NVMPS_CMD_RST 7'h00
`define NVMPS_WIN_RST 2'h0
`define NVMPS_PTR_RST 24'h000000

// ************************************************************
// command codes
// ************************************************************
`define NVMPS_CMD_NONE 7'h00
`define NVMPS_CMD_FL_PW 7'h04
`define NVMPS_CMD_FL_PER 7'h08
`define NVMPS_CMD_FL_PERW 7'h0c
`define NVMPS_CMD_FL_BCLR 7'h0f
`define NVMPS_CMD_EE_PW 7'h14
`define NVMPS_CMD_EE_PER 7'h18
`define NVMPS_CMD_EE_PERW 7'h1c
`define NVMPS_CMD_EE_BCLR 7'h1f
`define NVMPS_CMD_MPER_BASE 4'h4
`define NVMPS_CMD_EE_FULL 7'h30

// ************************************************************
// protection and timing
// ************************************************************
`define NVMPS_UNLOCK_KEY 8'h9d
`define NVMPS_UNLOCK_SPAN 3'h4
`define NVMPS_BCLR_STALL 4'h7

`endif

// ### nvmps_page_buf.v
/*
  One page buffer of the sequencer: byte array with a mark per byte.
  Assumes a single clock; unmarked bytes read as all ones.
*/
`timescale 1ns/1ns

module nvmps_page_buf #(
  parameter AW = 9
) (
  input wire clk,
  input wire rst_n,
  input wire clr,
  input wire wr,
  input wire [AW-1:0] waddr,
  input wire [7:0] wdata,
  input wire [AW-1:0] raddr,
  output wire [7:0] rdata,
  output wire rmark
);

  reg [7:0] mem [0:(1<<AW)-1];
  reg [(1<<AW)-1:0] mark;
  wire [7:0] old_byte;

  // ************************************************************
  // marks: clearing the marks makes the whole buffer read ones
  // ************************************************************
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      mark <= {(1<<AW){1'b0}};
    else if (clr || wr)
      mark <= (clr ? {(1<<AW){1'b0}} : mark) | ({{((1<<AW)-1){1'b0}}, wr} << waddr); // a store beside a clear keeps its mark
  end

  // new content is old content and-ed with the stored byte
  assign old_byte = (mark[waddr] && !clr) ? mem[waddr] : 8'hff;
  always @(posedge clk)
  begin
    if (wr)
      mem[waddr] <= old_byte & wdata;
  end

  // read port for the programming engine
  assign rdata = mark[raddr] ? mem[raddr] : 8'hff;
  assign rmark = mark[raddr];

endmodule // nvmps_page_buf

// ### nvmps_seq_properties.sv
/*
  Checker of the sequencer's bus answer and busy ports.
  Assumes it is bound to nvmps_sequencer and sees only its ports.
*/
`timescale 1ns/1ns

module nvmps_seq_properties (
  input wire clk,
  input wire rst_n,
  input wire sleep_wake,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_sel_i,
  input wire [19:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire flash_busy_flag,
  input wire eeprom_busy_flag
);
  reg [15:0] fl_cnt;
  wire arr_req = wb_cyc_i && wb_stb_i && wb_adr_i[19:15] == 5'h01;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ************************************************************
  // helper: length of the running flash operation
  // ************************************************************
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
      fl_cnt <= 16'h0000;
    else
      fl_cnt <= flash_busy_flag ? fl_cnt + 16'h0001 : 16'h0000;

  // ************************************************************
  // properties
  // ************************************************************
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
  property p_ack_cause;
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_busy_stall;
    arr_req && (flash_busy_flag || eeprom_busy_flag) |=> !wb_ack_o;
  endproperty
  a_busy_stall: assert property (p_busy_stall) else $error("array answered while busy");
  property p_arr_byte;
    wb_ack_o && !wb_we_i && arr_req |-> wb_dat_o[31:8] == 24'h000000;
  endproperty
  a_arr_byte: assert property (p_arr_byte) else $error("array read wider than a byte");
  property p_fl_start;
    $rose(flash_busy_flag) |-> $past(wb_ack_o && wb_we_i);
  endproperty
  a_fl_start: assert property (p_fl_start) else $error("flash busy without a store");
  property p_ee_start;
    $rose(eeprom_busy_flag) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i);
  endproperty
  a_ee_start: assert property (p_ee_start) else $error("eeprom busy without a write");
  property p_fl_len;
    $fell(flash_busy_flag) |-> fl_cnt >= 16'd63;
  endproperty
  a_fl_len: assert property (p_fl_len) else $error("flash operation too short");
  property p_status;
    wb_ack_o && !wb_we_i && wb_adr_i == 20'h0000c |->
      wb_dat_o[1:0] == {$past(flash_busy_flag), $past(eeprom_busy_flag)};
  endproperty
  a_status: assert property (p_status) else $error("status differs from busy ports");
endmodule // nvmps_seq_properties

bind nvmps_sequencer nvmps_seq_properties u_props (
  .clk(clk),
  .rst_n(rst_n),
  .sleep_wake(sleep_wake),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i),
  .wb_sel_i(wb_sel_i),
  .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .flash_busy_flag(flash_busy_flag),
  .eeprom_busy_flag(eeprom_busy_flag)
);

// ### nvmps_sequencer.v
/*
  Page program sequencer for code flash, user row and data eeprom,
  reached over a classic Wishbone slave with 32-bit data.
  Assumes one 125 MHz clock, inputs synchronous to it, async reset.
*/
`timescale 1ns/1ns
`include "nvmps_defines.vh"

module nvmps_sequencer #(
  parameter FL_BYTES = 65536,
  parameter FA_W = 16,
  parameter FP_W = 9,
  parameter EE_BYTES = 512,
  parameter EA_W = 9,
  parameter EP_W = 3
) (
  input wire clk,
  input wire rst_n,
  input wire sleep_wake,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_sel_i,
  input wire [19:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output wire flash_busy_flag,
  output wire eeprom_busy_flag
);

  localparam S_IDLE = 2'd0;
  localparam S_WAIT = 2'd1;
  localparam S_ACK = 2'd2;
  localparam T_NONE = 2'd0;
  localparam T_FL = 2'd1;
  localparam T_UR = 2'd2;
  localparam T_EE = 2'd3;
  localparam UR_W = 6;
  localparam integer EE_LAST = EE_BYTES - 1;

  reg [7:0] fl_mem [0:FL_BYTES-1];
  reg [7:0] ee_mem [0:EE_BYTES-1];
  reg [7:0] ur_mem [0:(1<<UR_W)-1];

  // bus side state
  reg [1:0] state;
  reg [3:0] wait_cnt;
  reg wait_eng;
  reg [6:0] cmd;
  reg [2:0] unl_cnt;
  reg [1:0] flash_window_select;
  reg [23:0] ptr;
  reg fb_clr_b;
  reg eb_clr_b;
  reg st_go;
  reg [1:0] st_tgt;
  reg st_er;
  reg st_wr;
  reg st_all;
  reg [FA_W-1:0] st_base;
  reg [FA_W-1:0] st_last;

  // engine state
  reg fl_busy;
  reg ee_busy;
  reg [1:0] op_tgt;
  reg op_wr;
  reg op_all;
  reg op_ph;
  reg [FA_W-1:0] op_base;
  reg [FA_W-1:0] op_idx;
  reg [FA_W-1:0] op_last;
  reg fb_clr_e;
  reg eb_clr_e;

  // decoded request
  reg [1:0] acc_tgt;
  reg acc_pm;
  reg acc_reg;
  reg [FA_W-1:0] acc_a;
  reg go_ok;
  reg go_er;
  reg go_wr;
  reg [FA_W-1:0] go_base;
  reg [FA_W-1:0] go_last;
  reg [31:0] rd_val;

  wire req;
  wire busy_any;
  wire acc_arr;
  wire take;
  wire [FA_W-1:0] op_a;
  wire [FA_W-1:0] win_a;
  wire [16:0] win_full;
  wire [FA_W-1:0] ptr_a;
  wire [7:0] fb_rd;
  wire [7:0] eb_rd;
  wire fb_mk;
  wire eb_mk;
  wire [7:0] unused_fb;
  wire fb_wr;
  wire eb_wr;

  // ************************************************************
  // request decode
  // ************************************************************
  function [1:0] region;
    input [19:0] a;
    begin
      if (a[19:9] == `NVMPS_RGN_EE)
        region = T_EE;
      else if (a[19:6] == `NVMPS_RGN_UR)
        region = T_UR;
      else if (a[19:15] == `NVMPS_RGN_FL)
        region = T_FL;
      else
        region = T_NONE;
    end
  endfunction

  // byte address from a word-in-page index, page number and byte pick
  function [FA_W-1:0] pm_byte;
    input [FA_W-FP_W-1:0] page_number_field;
    input [FP_W-2:0] word_in_page_index;
    input lsb;
    begin
      pm_byte = {page_number_field, word_in_page_index, lsb};
    end
  endfunction

  assign req = wb_cyc_i & wb_stb_i;
  assign busy_any = fl_busy | ee_busy;
  assign win_full = {flash_window_select, wb_adr_i[14:0]};
  assign win_a = win_full[FA_W-1:0];
  assign ptr_a = pm_byte(ptr[FA_W-1:FP_W], ptr[FP_W-1:1], ptr[0]);

  // address and target of the access, data space or pointer
  always @*
  begin
    acc_reg = (wb_adr_i[19:8] == `NVMPS_RGN_REG);
    acc_pm = acc_reg & (wb_adr_i[7:0] == `NVMPS_REG_PMDATA);
    acc_tgt = acc_pm ? T_FL : region(wb_adr_i);
    acc_a = acc_pm ? ptr_a : win_a;
    if (acc_tgt == T_EE)
      acc_a = {{(FA_W-EA_W){1'b0}}, wb_adr_i[EA_W-1:0]};
    else if (acc_tgt == T_UR)
      acc_a = {{(FA_W-UR_W){1'b0}}, wb_adr_i[UR_W-1:0]};
  end

  assign acc_arr = (acc_tgt != T_NONE);
  // array and buffer accesses hold off while any operation runs
  assign take = (state == S_IDLE) & req & !(acc_arr & busy_any);
  assign fb_wr = take & wb_we_i & wb_sel_i[0] & (acc_tgt == T_FL | acc_tgt == T_UR);
  assign eb_wr = take & wb_we_i & wb_sel_i[0] & (acc_tgt == T_EE);

  // ************************************************************
  // armed command against the store target
  // ************************************************************
  always @*
  begin
    go_ok = 1'b0;
    go_er = 1'b0;
    go_wr = 1'b0;
    go_base = {acc_a[FA_W-1:FP_W], {FP_W{1'b0}}};
    go_last = {{(FA_W-FP_W){1'b0}}, {FP_W{1'b1}}};
    if (acc_tgt == T_UR)
    begin
      go_base = {FA_W{1'b0}};
      go_last = {{(FA_W-UR_W){1'b0}}, {UR_W{1'b1}}};
    end
    if (acc_tgt == T_EE)
    begin
      go_base = {acc_a[FA_W-1:EP_W], {EP_W{1'b0}}};
      go_last = {{(FA_W-EP_W){1'b0}}, {EP_W{1'b1}}};
      go_ok = (cmd == `NVMPS_CMD_EE_PW) | (cmd == `NVMPS_CMD_EE_PER) | (cmd == `NVMPS_CMD_EE_PERW);
      go_er = (cmd == `NVMPS_CMD_EE_PER) | (cmd == `NVMPS_CMD_EE_PERW);
      go_wr = (cmd == `NVMPS_CMD_EE_PW) | (cmd == `NVMPS_CMD_EE_PERW);
    end
    else if (acc_arr)
    begin
      go_ok = (cmd == `NVMPS_CMD_FL_PW) | (cmd == `NVMPS_CMD_FL_PER) | (cmd == `NVMPS_CMD_FL_PERW);
      go_er = (cmd == `NVMPS_CMD_FL_PER) | (cmd == `NVMPS_CMD_FL_PERW);
      go_wr = (cmd == `NVMPS_CMD_FL_PW) | (cmd == `NVMPS_CMD_FL_PERW);
      if (acc_tgt == T_FL && cmd[6:3] == `NVMPS_CMD_MPER_BASE && cmd[2:0] >= 3'd1 && cmd[2:0] <= 3'd5)
      begin
        go_ok = 1'b1;
        go_er = 1'b1;
        go_last = (({{(FA_W-FP_W){1'b0}}, {FP_W{1'b1}}} + 1'b1) << cmd[2:0]) - 1'b1;
        go_base = acc_a & ~go_last;
      end
    end
  end

  // ************************************************************
  // read data mux
  // ************************************************************
  always @*
  begin
    rd_val = 32'h00000000;
    if (acc_tgt == T_EE)
      rd_val = {24'h000000, ee_mem[acc_a[EA_W-1:0]]};
    else if (acc_tgt == T_UR)
      rd_val = {24'h000000, ur_mem[acc_a[UR_W-1:0]]};
    else if (acc_tgt == T_FL)
      rd_val = {24'h000000, fl_mem[acc_a]};
    else if (acc_reg && wb_adr_i[7:0] == `NVMPS_REG_CMD)
      rd_val = {25'h0000000, cmd};
    else if (acc_reg && wb_adr_i[7:0] == `NVMPS_REG_WINDOW)
      rd_val = {30'h00000000, flash_window_select};
    else if (acc_reg && wb_adr_i[7:0] == `NVMPS_REG_STATUS)
    begin
      rd_val[`NVMPS_STAT_FL_BIT] = fl_busy;
      rd_val[`NVMPS_STAT_EE_BIT] = ee_busy;
    end
    else if (acc_reg && wb_adr_i[7:0] == `NVMPS_REG_PTR)
      rd_val = {8'h00, ptr};
  end

  // ************************************************************
  // bus slave and command register
  // ************************************************************
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= S_IDLE;
      wait_cnt <= 4'h0;
      wait_eng <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      cmd <= `NVMPS_CMD_RST;
      unl_cnt <= 3'h0;
      flash_window_select <= `NVMPS_WIN_RST;
      ptr <= `NVMPS_PTR_RST;
      fb_clr_b <= 1'b0;
      eb_clr_b <= 1'b0;
      st_go <= 1'b0;
      st_tgt <= T_NONE;
      st_er <= 1'b0;
      st_wr <= 1'b0;
      st_all <= 1'b0;
      st_base <= {FA_W{1'b0}};
      st_last <= {FA_W{1'b0}};
    end
    else
    begin
      fb_clr_b <= 1'b0;
      eb_clr_b <= 1'b0;
      st_go <= 1'b0;
      case (state)
        S_IDLE:
        begin
          if (take)
          begin
            wb_dat_o <= wb_we_i ? 32'h00000000 : rd_val;
            state <= S_ACK;
            wb_ack_o <= 1'b1;
            if (unl_cnt != 3'h0)
              unl_cnt <= unl_cnt - 3'h1;
            if (wb_we_i && acc_arr && wb_sel_i[0] && go_ok)
            begin
              // a store starts the armed operation
              st_go <= 1'b1;
              st_tgt <= acc_tgt;
              st_er <= go_er;
              st_wr <= go_wr;
              st_all <= (acc_tgt != T_EE);
              st_base <= go_base;
              st_last <= go_last;
            end
            else if (wb_we_i && acc_reg && wb_sel_i[0])
            begin
              if (wb_adr_i[7:0] == `NVMPS_REG_UNLOCK && wb_dat_i[7:0] == `NVMPS_UNLOCK_KEY)
                unl_cnt <= `NVMPS_UNLOCK_SPAN;
              else if (wb_adr_i[7:0] == `NVMPS_REG_WINDOW)
                flash_window_select <= wb_dat_i[1:0];
              else if (wb_adr_i[7:0] == `NVMPS_REG_CMD && unl_cnt != 3'h0)
              begin
                // only an unlocked write reaches the command
                cmd <= wb_dat_i[6:0];
                unl_cnt <= 3'h0;
                if (wb_dat_i[6:0] == `NVMPS_CMD_FL_BCLR || wb_dat_i[6:0] == `NVMPS_CMD_EE_BCLR)
                begin
                  fb_clr_b <= (wb_dat_i[6:0] == `NVMPS_CMD_FL_BCLR);
                  eb_clr_b <= (wb_dat_i[6:0] == `NVMPS_CMD_EE_BCLR);
                  wb_ack_o <= 1'b0;
                  state <= S_WAIT;
                  wait_cnt <= `NVMPS_BCLR_STALL - 4'h1;
                  wait_eng <= 1'b0;
                end
                else if (wb_dat_i[6:0] == `NVMPS_CMD_EE_FULL && !ee_busy)
                begin
                  st_go <= 1'b1;
                  st_tgt <= T_EE;
                  st_er <= 1'b1;
                  st_wr <= 1'b0;
                  st_all <= 1'b1;
                  st_base <= {FA_W{1'b0}};
                  st_last <= EE_LAST[FA_W-1:0];
                  wb_ack_o <= 1'b0;
                  state <= S_WAIT;
                  wait_cnt <= 4'h1;
                  wait_eng <= 1'b1;
                end
              end
            end
            if (wb_we_i && acc_reg && wb_adr_i[7:0] == `NVMPS_REG_PTR)
            begin
              if (wb_sel_i[0])
                ptr[7:0] <= wb_dat_i[7:0];
              if (wb_sel_i[1])
                ptr[15:8] <= wb_dat_i[15:8];
              if (wb_sel_i[2])
                ptr[23:16] <= wb_dat_i[23:16];
            end
          end
        end
        S_WAIT:
        begin
          // stall the bus for the clear or the full erase
          if (wait_cnt != 4'h0)
            wait_cnt <= wait_cnt - 4'h1;
          else if (!(wait_eng && ee_busy))
          begin
            state <= S_ACK;
            wb_ack_o <= 1'b1;
          end
        end
        default:
        begin
          wb_ack_o <= 1'b0;
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // programming engine, one byte per cycle
  // ************************************************************
  assign op_a = op_base + op_idx;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fl_busy <= 1'b0;
      ee_busy <= 1'b0;
      op_tgt <= T_NONE;
      op_wr <= 1'b0;
      op_all <= 1'b0;
      op_ph <= 1'b0;
      op_base <= {FA_W{1'b0}};
      op_idx <= {FA_W{1'b0}};
      op_last <= {FA_W{1'b0}};
      fb_clr_e <= 1'b0;
      eb_clr_e <= 1'b0;
    end
    else
    begin
      fb_clr_e <= 1'b0;
      eb_clr_e <= 1'b0;
      if (st_go)
      begin
        fl_busy <= (st_tgt != T_EE);
        ee_busy <= (st_tgt == T_EE);
        op_tgt <= st_tgt;
        op_wr <= st_wr;
        op_all <= st_all;
        op_ph <= !st_er;
        op_base <= st_base;
        op_last <= st_last;
        op_idx <= {FA_W{1'b0}};
      end
      else if (busy_any)
      begin
        if (op_idx != op_last)
          op_idx <= op_idx + 1'b1;
        else
        begin
          op_idx <= {FA_W{1'b0}};
          if (!op_ph && op_wr)
            op_ph <= 1'b1;
          else
          begin
            fl_busy <= 1'b0;
            ee_busy <= 1'b0;
            fb_clr_e <= (op_tgt != T_EE);
            eb_clr_e <= (op_tgt == T_EE) & (op_last != EE_LAST[FA_W-1:0]);
          end
        end
      end
    end
  end

  // array updates: erase to ones, write ands in the buffer
  always @(posedge clk)
  begin
    if (busy_any && !st_go)
    begin
      if (op_tgt == T_FL)
        fl_mem[op_a] <= op_ph ? (fl_mem[op_a] & fb_rd) : 8'hff;
      else if (op_tgt == T_UR)
        ur_mem[op_a[UR_W-1:0]] <= op_ph ? (ur_mem[op_a[UR_W-1:0]] & fb_rd) : 8'hff;
      else if (op_tgt == T_EE && (op_all || eb_mk))
        ee_mem[op_a[EA_W-1:0]] <= op_ph ? (ee_mem[op_a[EA_W-1:0]] & eb_rd) : 8'hff;
    end
  end

  // ************************************************************
  // page buffers
  // ************************************************************
  nvmps_page_buf #(
    .AW(FP_W)
  ) u_fl_buf (
    .clk(clk),
    .rst_n(rst_n),
    .clr(fb_clr_b | fb_clr_e | sleep_wake),
    .wr(fb_wr),
    .waddr(acc_a[FP_W-1:0]),
    .wdata(wb_dat_i[7:0]),
    .raddr(op_a[FP_W-1:0]),
    .rdata(fb_rd),
    .rmark(fb_mk)
  );

  nvmps_page_buf #(
    .AW(EP_W)
  ) u_ee_buf (
    .clk(clk),
    .rst_n(rst_n),
    .clr(eb_clr_b | eb_clr_e | sleep_wake),
    .wr(eb_wr),
    .waddr(acc_a[EP_W-1:0]),
    .wdata(wb_dat_i[7:0]),
    .raddr(op_a[EP_W-1:0]),
    .rdata(eb_rd),
    .rmark(eb_mk)
  );

  // busy flags leave from registers; eeprom work holds off array accesses, a full erase stalls the bus
  assign flash_busy_flag = fl_busy;
  assign eeprom_busy_flag = ee_busy;
  assign unused_fb = {7'h00, fb_mk};

endmodule // nvmps_sequencer
